// ### hdl/ifthr_pkg.sv
// constants and carriers for the input fault threshold register bank
// assumes a single 200 MHz clock domain; nothing else is shared
package ifthr_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] TERM_BATT_ADDR = 8'h65;
   localparam logic [7:0] GND_BIAS_ADDR = 8'h66;
   localparam logic [7:0] SCAN_CFG_ADDR = 8'h67;
   // reset values and the data returned by unmapped reads
   localparam logic [7:0] TERM_BATT_RST = 8'h37;
   localparam logic [7:0] GND_BIAS_RST = 8'h87;
   localparam logic [7:0] SCAN_CFG_RST = 8'hB8;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // field positions
   localparam int HI_NIB_LSB = 4;
   localparam int LO_NIB_LSB = 0;
   localparam int REPEAT_LSB = 6;
   localparam int FILTER_LSB = 2;
   localparam int BATT_FILTER_BIT = 1;
   localparam int DOUBLE_BIT = 0;
   // threshold scale
   localparam int MV_W = 11;
   localparam logic [MV_W-1:0] STEP_30_MV = 11'h01E;
   localparam logic [MV_W-1:0] STEP_60_MV = 11'h03C;
   // scan repeat timing
   localparam int CLK_MHZ = 200;
   localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
   localparam int REPEAT_1_MS = 1;
   localparam int REPEAT_4_MS = 4;
   localparam int REPEAT_8_MS = 8;
   localparam int REPEAT_1_CYCLES = REPEAT_1_MS * CYCLES_PER_MS;
   localparam int REPEAT_4_CYCLES = REPEAT_4_MS * CYCLES_PER_MS;
   localparam int REPEAT_8_CYCLES = REPEAT_8_MS * CYCLES_PER_MS;
   localparam int TIMER_W = 21;
   // fault filter counts
   localparam int FILTER_W = 5;
   localparam logic [FILTER_W-1:0] FILTER_16 = 5'h10;
   localparam logic [FILTER_W-1:0] FILTER_8 = 5'h08;
   localparam logic [FILTER_W-1:0] FILTER_4 = 5'h04;
   localparam logic [FILTER_W-1:0] FILTER_NONE = 5'h00;

   typedef struct packed {
      logic [7:0] term_batt;
      logic [7:0] gnd_bias;
      logic [7:0] scan_cfg;
   } ifthr_regs_s;

   typedef struct packed {
      logic [MV_W-1:0] terminal;
      logic [MV_W-1:0] battery;
      logic [MV_W-1:0] ground;
      logic [MV_W-1:0] bias;
   } ifthr_thresh_s;
endpackage : ifthr_pkg

// ### hdl/ifthr_decode.sv
// one threshold decoder: 4-bit code to millivolts, registered
// assumes code and double flag come from flops in the same domain
`timescale 1ns/1ps
module ifthr_decode #(
   parameter int MV_W = 11
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic ce, // clock enable
   input wire logic [3:0] code, // threshold code
   input wire logic [MV_W-1:0] step_mv, // millivolts per code
   input wire logic double_scale, // scale result by two
   output logic [MV_W-1:0] mv_q // decoded threshold
);
   typedef struct packed {
      logic [MV_W-1:0] mv;
   } ifthr_dec_s;

   ifthr_dec_s st_q;
   ifthr_dec_s st_d;
   logic [MV_W-1:0] lin;

   always_comb begin
      st_d = st_q;
      // linear over all codes, endpoints included
      lin = MV_W'({{(MV_W-4){1'b0}}, code} * step_mv);
      st_d.mv = double_scale ? MV_W'({lin, 1'b0}) : lin;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign mv_q = st_q.mv;
endmodule : ifthr_decode

// ### hdl/ifthr_regs.sv
// input fault threshold register bank with decoded configuration outputs
// assumes the control-port front end delivers one-cycle read/write strobes
`timescale 1ns/1ps
module ifthr_regs #(
   parameter int REPEAT_1_CYCLES = ifthr_pkg::REPEAT_1_CYCLES,
   parameter int REPEAT_4_CYCLES = ifthr_pkg::REPEAT_4_CYCLES,
   parameter int REPEAT_8_CYCLES = ifthr_pkg::REPEAT_8_CYCLES
) (
   input wire logic clk, // system clock, 200 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic [7:0] reg_addr, // register address
   input wire logic reg_wr, // write strobe
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata_q, // read data, valid with reg_rvalid_q
   output logic reg_rvalid_q, // read answer pulse
   output ifthr_pkg::ifthr_thresh_s thresh_q, // decoded thresholds in mV
   output logic [1:0] scan_repeat_interval_q, // interval code
   output logic scan_start_q, // one pulse per scan start
   output logic [ifthr_pkg::FILTER_W-1:0] fault_filter_count_q, // counts, 0 = off
   output logic fault_filter_off_q, // filtering disabled
   output logic [ifthr_pkg::FILTER_W-1:0] battery_fault_filter_count_q, // counts
   output logic threshold_double_scale_q // thresholds doubled
);
   // last timer value of each period; the timer counts from zero
   localparam logic [ifthr_pkg::TIMER_W-1:0] T1 = ifthr_pkg::TIMER_W'(REPEAT_1_CYCLES - 1);
   localparam logic [ifthr_pkg::TIMER_W-1:0] T4 = ifthr_pkg::TIMER_W'(REPEAT_4_CYCLES - 1);
   localparam logic [ifthr_pkg::TIMER_W-1:0] T8 = ifthr_pkg::TIMER_W'(REPEAT_8_CYCLES - 1);

   typedef struct packed {
      ifthr_pkg::ifthr_regs_s regs;
      logic [7:0] rdata;
      logic rvalid;
      logic [ifthr_pkg::TIMER_W-1:0] timer;
      logic scan_start;
      logic [ifthr_pkg::FILTER_W-1:0] filter;
      logic filter_off;
      logic [ifthr_pkg::FILTER_W-1:0] batt_filter;
   } ifthr_state_s;

   ifthr_state_s st_q;
   ifthr_state_s st_d;
   logic [1:0] interval_code;
   logic [1:0] filter_code;
   logic [ifthr_pkg::TIMER_W-1:0] interval_last;
   logic double_scale;
   logic scan_cfg_wr;

   // nibble codes and their decoded millivolts, one pair per threshold
   logic [3:0] term_code;
   logic [3:0] batt_code;
   logic [3:0] gnd_code;
   logic [3:0] bias_code;
   logic [ifthr_pkg::MV_W-1:0] term_mv;
   logic [ifthr_pkg::MV_W-1:0] batt_mv;
   logic [ifthr_pkg::MV_W-1:0] gnd_mv;
   logic [ifthr_pkg::MV_W-1:0] bias_mv;

   assign interval_code = st_q.regs.scan_cfg[ifthr_pkg::REPEAT_LSB +: 2];
   assign filter_code = st_q.regs.scan_cfg[ifthr_pkg::FILTER_LSB +: 2];
   assign double_scale = st_q.regs.scan_cfg[ifthr_pkg::DOUBLE_BIT];
   assign scan_cfg_wr = reg_wr && (reg_addr == ifthr_pkg::SCAN_CFG_ADDR);

   assign term_code = st_q.regs.term_batt[ifthr_pkg::HI_NIB_LSB +: 4];
   assign batt_code = st_q.regs.term_batt[ifthr_pkg::LO_NIB_LSB +: 4];
   assign gnd_code = st_q.regs.gnd_bias[ifthr_pkg::HI_NIB_LSB +: 4];
   assign bias_code = st_q.regs.gnd_bias[ifthr_pkg::LO_NIB_LSB +: 4];

   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      // all three registers are fully read-write, reserved bits included
      if (reg_wr) begin
         unique case (reg_addr)
            ifthr_pkg::TERM_BATT_ADDR: st_d.regs.term_batt = reg_wdata;
            ifthr_pkg::GND_BIAS_ADDR: st_d.regs.gnd_bias = reg_wdata;
            ifthr_pkg::SCAN_CFG_ADDR: st_d.regs.scan_cfg = reg_wdata;
            default: ;
         endcase
      end

      if (reg_rd) begin
         st_d.rvalid = 1'b1;
         unique case (reg_addr)
            ifthr_pkg::TERM_BATT_ADDR: st_d.rdata = st_q.regs.term_batt;
            ifthr_pkg::GND_BIAS_ADDR: st_d.rdata = st_q.regs.gnd_bias;
            ifthr_pkg::SCAN_CFG_ADDR: st_d.rdata = st_q.regs.scan_cfg;
            default: st_d.rdata = ifthr_pkg::UNMAPPED_READ;
         endcase
      end

      // code 0 gives a start every cycle, no idle time
      unique case (interval_code)
         2'h0: interval_last = '0;
         2'h1: interval_last = T1;
         2'h2: interval_last = T4;
         2'h3: interval_last = T8;
      endcase

      // a write to the scan register restarts the period so a new interval applies cleanly
      if (scan_cfg_wr) begin
         st_d.timer = '0;
         st_d.scan_start = 1'b0;
      end else if (st_q.timer >= interval_last) begin
         st_d.timer = '0;
         st_d.scan_start = 1'b1;
      end else begin
         st_d.timer = st_q.timer + 1'b1;
         st_d.scan_start = 1'b0;
      end

      unique case (filter_code)
         2'h0: st_d.filter = ifthr_pkg::FILTER_16;
         2'h1: st_d.filter = ifthr_pkg::FILTER_8;
         2'h2: st_d.filter = ifthr_pkg::FILTER_4;
         2'h3: st_d.filter = ifthr_pkg::FILTER_NONE;
      endcase
      st_d.filter_off = (filter_code == 2'h3);
      // battery shorts use their own filter, 16 or 8 counts, never switched off
      if (st_q.regs.scan_cfg[ifthr_pkg::BATT_FILTER_BIT]) begin
         st_d.batt_filter = ifthr_pkg::FILTER_8;
      end else begin
         st_d.batt_filter = ifthr_pkg::FILTER_16;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q.rdata <= '0;
         st_q.rvalid <= 1'b0;
         st_q.timer <= '0;
         st_q.scan_start <= 1'b0;
         st_q.filter_off <= 1'b0;
         st_q.regs.term_batt <= ifthr_pkg::TERM_BATT_RST;
         st_q.regs.gnd_bias <= ifthr_pkg::GND_BIAS_RST;
         st_q.regs.scan_cfg <= ifthr_pkg::SCAN_CFG_RST;
         st_q.filter <= ifthr_pkg::FILTER_4;
         st_q.batt_filter <= ifthr_pkg::FILTER_16;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // 30 mV fields share one step; the ground field alone uses 60 mV
   ifthr_decode #(
      .MV_W(ifthr_pkg::MV_W)
   ) u_term (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .code(term_code),
      .step_mv(ifthr_pkg::STEP_30_MV),
      .double_scale(double_scale),
      .mv_q(term_mv)
   );

   ifthr_decode #(
      .MV_W(ifthr_pkg::MV_W)
   ) u_batt (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .code(batt_code),
      .step_mv(ifthr_pkg::STEP_30_MV),
      .double_scale(double_scale),
      .mv_q(batt_mv)
   );

   ifthr_decode #(
      .MV_W(ifthr_pkg::MV_W)
   ) u_gnd (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .code(gnd_code),
      .step_mv(ifthr_pkg::STEP_60_MV),
      .double_scale(double_scale),
      .mv_q(gnd_mv)
   );

   ifthr_decode #(
      .MV_W(ifthr_pkg::MV_W)
   ) u_bias (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .code(bias_code),
      .step_mv(ifthr_pkg::STEP_30_MV),
      .double_scale(double_scale),
      .mv_q(bias_mv)
   );

   assign reg_rdata_q = st_q.rdata;
   assign reg_rvalid_q = st_q.rvalid;
   assign scan_repeat_interval_q = interval_code;
   assign scan_start_q = st_q.scan_start;
   assign fault_filter_count_q = st_q.filter;
   assign fault_filter_off_q = st_q.filter_off;
   assign battery_fault_filter_count_q = st_q.batt_filter;
   assign threshold_double_scale_q = double_scale;

   // one driver for the whole bundle; every field still comes from a decoder flop
   assign thresh_q = '{
      terminal: term_mv,
      battery: batt_mv,
      ground: gnd_mv,
      bias: bias_mv
   };
endmodule : ifthr_regs

// ### dv/ifthr_properties.sv
// port checker for the threshold register bank
// bound into ifthr_regs below; single clock domain
`timescale 1ns/1ps
module ifthr_properties #(
   parameter int REPEAT_1_CYCLES = 10,
   parameter int REPEAT_4_CYCLES = 40,
   parameter int REPEAT_8_CYCLES = 80
) (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic ce, // enable
   input wire logic [7:0] reg_addr, // address
   input wire logic reg_wr, // write
   input wire logic [7:0] reg_wdata, // wdata
   input wire logic reg_rd, // read
   input wire logic [7:0] reg_rdata_q, // rdata
   input wire logic reg_rvalid_q, // rvalid
   input wire ifthr_pkg::ifthr_thresh_s thresh_q, // mV
   input wire logic [1:0] scan_repeat_interval_q, // interval
   input wire logic scan_start_q, // scan pulse
   input wire logic [ifthr_pkg::FILTER_W-1:0] fault_filter_count_q, // counts
   input wire logic fault_filter_off_q, // filter off
   input wire logic [ifthr_pkg::FILTER_W-1:0] battery_fault_filter_count_q, // counts
   input wire logic threshold_double_scale_q // double
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   int gap_q;
   // cycles since the last scan pulse or period restart; frozen with the enable
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_q <= 0;
      end else if (ce) begin
         if (reg_wr && reg_addr == 8'h67) begin
            gap_q <= 0;
         end else if (scan_start_q) begin
            gap_q <= 1;
         end else begin
            gap_q <= gap_q + 1;
         end
      end
   end
   a_read_answered: assert property (reg_rd && ce |=> reg_rvalid_q) else $error("read not answered");
   a_rvalid_caused: assert property (reg_rvalid_q |-> $past(reg_rd && ce)) else $error("stray rvalid");
   a_rdata_held: assert property (!reg_rvalid_q |-> $stable(reg_rdata_q)) else $error("rdata moved");
   a_scan_period: assert property (scan_start_q && ce |-> gap_q == (scan_repeat_interval_q == 2'h0 ? 1 :
      scan_repeat_interval_q == 2'h1 ? REPEAT_1_CYCLES : scan_repeat_interval_q == 2'h2 ? REPEAT_4_CYCLES
      : REPEAT_8_CYCLES)) else $error("scan period wrong");
   a_unmapped_zero: assert property (reg_rd && ce && !(reg_addr inside {8'h65, 8'h66, 8'h67})
      |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
   a_write_readback: assert property (reg_wr && ce && reg_addr == 8'h66 ##1 !reg_wr ##1 reg_rd && ce && !reg_wr
      && reg_addr == 8'h66 |=> reg_rdata_q == $past(reg_wdata, 3)) else $error("readback differs");
   a_scan_cfg_load: assert property (reg_wr && ce && reg_addr == 8'h67 |=> !scan_start_q &&
      {scan_repeat_interval_q, threshold_double_scale_q} == {$past(reg_wdata[7:6]), $past(reg_wdata[0])})
      else $error("scan config not loaded");
   a_filter_off: assert property (fault_filter_off_q == (fault_filter_count_q == 5'h00)) else $error("filter off");
   a_filter_legal: assert property (fault_filter_count_q inside {5'h10, 5'h08, 5'h04, 5'h00} &&
      battery_fault_filter_count_q inside {5'h10, 5'h08}) else $error("filter count illegal");
   a_ground_step: assert property (thresh_q.ground % 60 == 0 && thresh_q.terminal <= 11'h384)
      else $error("threshold off scale");
   c_readback: cover property (reg_rvalid_q && reg_rdata_q != 8'h00);
   c_doubled: cover property (threshold_double_scale_q && thresh_q.ground == 11'h708);
   c_filter_off: cover property (fault_filter_off_q);
   c_back_to_back: cover property (scan_repeat_interval_q == 2'h0 && scan_start_q);
endmodule : ifthr_properties

bind ifthr_regs ifthr_properties #(.REPEAT_1_CYCLES(REPEAT_1_CYCLES), .REPEAT_4_CYCLES(REPEAT_4_CYCLES),
   .REPEAT_8_CYCLES(REPEAT_8_CYCLES)) u_props (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .reg_rvalid_q(reg_rvalid_q), .thresh_q(thresh_q), .scan_repeat_interval_q(scan_repeat_interval_q),
   .scan_start_q(scan_start_q), .fault_filter_count_q(fault_filter_count_q),
   .fault_filter_off_q(fault_filter_off_q), .battery_fault_filter_count_q(battery_fault_filter_count_q),
   .threshold_double_scale_q(threshold_double_scale_q));

// ### dv/testbench.sv
// self-checking bench for the threshold register bank
// assumes the checker binds itself; short scan periods for speed
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
   logic reg_rvalid_q, scan_start_q, fault_filter_off_q, threshold_double_scale_q;
   logic [1:0] scan_repeat_interval_q;
   logic [ifthr_pkg::FILTER_W-1:0] fault_filter_count_q, battery_fault_filter_count_q;
   ifthr_pkg::ifthr_thresh_s thresh_q;
   int n_fail = 0, check_count = 0, cycles = 0;
   ifthr_regs #(.REPEAT_1_CYCLES(10), .REPEAT_4_CYCLES(40), .REPEAT_8_CYCLES(80)) dut (.clk(clk), .rst(rst),
      .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .thresh_q(thresh_q),
      .scan_repeat_interval_q(scan_repeat_interval_q), .scan_start_q(scan_start_q),
      .fault_filter_count_q(fault_filter_count_q), .fault_filter_off_q(fault_filter_off_q),
      .battery_fault_filter_count_q(battery_fault_filter_count_q),
      .threshold_double_scale_q(threshold_double_scale_q));
   always #2.5 clk = ~clk;
   task automatic chk(input logic [43:0] got, input logic [43:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rvalid_q, 1'b1);
      d = reg_rdata_q;
   endtask : rd
   task automatic t_reset;
      logic [7:0] d;
      rd(8'h65, d);
      chk(d, 8'h37);
      rd(8'h66, d);
      chk(d, 8'h87);
      rd(8'h67, d);
      chk(d, 8'hB8);
      chk(thresh_q, {11'h05A, 11'h0D2, 11'h1E0, 11'h0D2});
      chk({scan_repeat_interval_q, threshold_double_scale_q, fault_filter_count_q}, {2'h2, 1'h0, 5'h04});
      chk(battery_fault_filter_count_q, 5'h10);
      $display("test reset done");
   endtask : t_reset
   task automatic t_codes;
      int m, c;
      for (m = 0; m < 2; m++) begin
         wr(8'h67, {7'h5C, 1'(m)});
         for (c = 0; c < 16; c++) begin
            wr(8'h65, {4'(c), 4'(c)});
            wr(8'h66, {4'(c), 4'(c)});
            repeat (2) @(posedge clk);
            #1;
            chk(thresh_q, {11'(c * 30 << m), 11'(c * 30 << m), 11'(c * 60 << m), 11'(c * 30 << m)});
         end
      end
      $display("test codes done");
   endtask : t_codes
   task automatic t_filter;
      int s;
      int f[4] = '{16, 8, 4, 0};
      for (s = 0; s < 4; s++) begin
         wr(8'h67, {4'hB, 2'(s), 1'(s), 1'b0});
         repeat (2) @(posedge clk);
         #1;
         chk({fault_filter_count_q, fault_filter_off_q, battery_fault_filter_count_q},
            {5'(f[s]), 1'(s == 3), 5'(s % 2 ? 8 : 16)});
      end
      $display("test filter done");
   endtask : t_filter
   task automatic t_interval;
      int i, k, n;
      int g[4] = '{1, 10, 40, 80};
      for (i = 0; i < 4; i++) begin
         wr(8'h67, {2'(i), 6'h38});
         for (n = 0; n < 2; n++) begin
            k = 0;
            do begin @(posedge clk); #1; k++; end while (scan_start_q !== 1'b1 && k < 100);
         end
         chk(k, g[i]);
      end
      $display("test interval done");
   endtask : t_interval
   task automatic t_unmapped;
      logic [7:0] d;
      wr(8'h68, 8'h00);
      rd(8'h66, d);
      chk(d, 8'hFF);
      rd(8'h64, d);
      chk(d, 8'h00);
      wr(8'h66, 8'h5A);
      rd(8'h66, d);
      chk(d, 8'h5A);
      $display("test unmapped done");
   endtask : t_unmapped
   task automatic t_freeze;
      logic [7:0] d;
      @(posedge clk);
      ce <= 1'b0;
      wr(8'h66, 8'hC3);
      @(posedge clk);
      ce <= 1'b1;
      rd(8'h66, d);
      chk(d, 8'h5A);
      chk({thresh_q.ground, thresh_q.bias}, {11'h12C, 11'h12C});
      $display("test freeze done");
   endtask : t_freeze
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_codes();
      t_filter();
      t_interval();
      t_unmapped();
      t_freeze();
      report_and_stop();
   end
endmodule : testbench
